/* rtl/l2_err_pkg.sv */
// Package of constants and carrier types for the cache error capture block
package l2_err_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 40;
    localparam logic [ADDR_W-1:0] L2_ERROR_STATUS_ADDR = 40'hff_fff0_00e8;
    localparam logic [ADDR_W-1:0] L2_ERROR_ADDRESS_ADDR = 40'hff_fff0_0188;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int TPERR_LSB = 0;
    localparam int DPERR_LSB = 3;
    localparam int CMD_LSB = 11;
    localparam int SCND_BIT = 16;
    localparam logic [63:0] STATUS_RESERVED_VAL = 64'h0000_0000_0000_0000;

    // ------------------------------------------------------------
    // Address register fields
    // ------------------------------------------------------------
    localparam int CAP_LSB = 4;
    localparam int CAP_W = 35;
    localparam int FH_TAG_LSB = 15;
    localparam int FH_TAG_W = 24;
    localparam logic [3:0] ADDR_LOW_FILL = 4'hf;
    localparam logic [23:0] ADDR_HIGH_FILL = 24'hff_ffff;

    // ------------------------------------------------------------
    // Transaction codes (low three bits)
    // ------------------------------------------------------------
    localparam logic [2:0] OP_SET_SHARED = 3'h6;
    localparam logic [2:0] OP_READ_DIRTY = 3'h5;
    localparam logic [2:0] OP_INVALIDATE = 3'h4;
    localparam logic [2:0] OP_DATA_WRITE = 3'h3;
    localparam logic [2:0] OP_READ_VICTIM = 3'h1;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    // Lookup request, presented in the tag access cycle
    typedef struct packed {
        logic valid;
        logic [4:0] cmd;
        logic [ADDR_W-1:0] addr;
        logic is_read_or_probe;
    } lookup_req_t;

    // Tag readout, presented with the first octaword
    typedef struct packed {
        logic [2:0] tag_perr;
        logic tag_parity_bit;
        logic [2:0] subblock0_vsd;
        logic [2:0] subblock1_vsd;
        logic [1:0] subblock0_modified;
        logic [1:0] subblock1_modified;
        logic [FH_TAG_W-1:0] tag;
    } tag_read_t;

    // One octaword data readout
    typedef struct packed {
        logic valid;
        logic [3:0] lw_perr;
        logic [3:0] lw_parity;
    } data_read_t;

endpackage : l2_err_pkg

/* rtl/l2_err_reg_decode.sv */
// Register read decoder for the cache error capture block
`timescale 1ns/1ns
`default_nettype none
module l2_err_reg_decode (
    input wire logic [l2_err_pkg::ADDR_W-1:0] addr,
    input wire logic rd_stb,
    output logic rd_status,
    output logic rd_address
);
    import l2_err_pkg::*;

    always_comb begin
        rd_status = rd_stb && (addr == L2_ERROR_STATUS_ADDR);
        rd_address = rd_stb && (addr == L2_ERROR_ADDRESS_ADDR);
    end

endmodule : l2_err_reg_decode
`default_nettype wire

/* rtl/l2_cache_error_capture.sv */
// Second-level cache error capture: status and address registers
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Status read-only, survives reset, stays locked
// - Status read clears and unlocks both
// - Parity error locks status against later updates
// - Three-bit tag parity field, one per set
// - Eight-bit longword data parity field
// - Force-hit loads longword parity bits instead
// - Transaction code written with error bit
// - Low code bits encode operation kind
// - Second error flag on later transaction
// - No second error within same transaction
// - Address loads every access while unlocked
// - Address locks on error, unlocks on read
// - Bits 38:4 valid, bit 39 zero
// - One tag cycle, two data cycles
// - Tag checked first octaword, data both
// - Force-hit: reads and probes load tag status
// - Force-hit disables checking; loaded parity bits set the lock
// - Tag holds per-subblock status, shared parity
// - Force-hit address layout of tag fields
module l2_cache_error_capture (
    input wire logic clk,
    input wire logic resetn,
    input wire logic force_hit_mode,
    input wire l2_err_pkg::lookup_req_t lookup,
    input wire l2_err_pkg::tag_read_t tag_rd,
    input wire l2_err_pkg::data_read_t oct_rd,
    input wire logic [l2_err_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [63:0] reg_rdata,
    output logic error_locked
);
    import l2_err_pkg::*;

    // ------------------------------------------------------------
    // Lookup sequencing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, OCT0, OCT1} phase_t;

    phase_t phase_r;
    logic [4:0] cmd_r;
    logic oct0_valid_r;
    logic [3:0] oct0_perr_r;
    logic [3:0] oct0_par_r;
    logic [2:0] tag_perr_r;
    logic fh_r;
    logic rdp_r;

    // Status and address register state
    logic [2:0] tperr_r;
    logic [7:0] dperr_r;
    logic [4:0] stat_cmd_r;
    logic scnd_r;
    logic [CAP_W-1:0] cap_r;

    logic rd_status;
    logic rd_address;
    logic err_now;
    logic locked;
    logic [7:0] dp_all;
    logic [7:0] par_all;
    logic [CAP_W-1:0] fh_word;

    l2_err_reg_decode u_dec (
        .addr(reg_addr),
        .rd_stb(reg_rd),
        .rd_status(rd_status),
        .rd_address(rd_address)
    );

    function automatic logic [CAP_W-1:0] pack_tag(input tag_read_t t);
        pack_tag = {t.tag, t.subblock1_modified, t.subblock0_modified,
                    t.subblock1_vsd, t.subblock0_vsd, t.tag_parity_bit};
    endfunction : pack_tag

    // Phase tracker: tag cycle, then two consecutive data cycles
    // Phase state is control, so it is reset; captured state is not
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= IDLE;
        end else begin
            unique case (phase_r)
                IDLE: phase_r <= lookup.valid ? OCT0 : IDLE;
                OCT0: phase_r <= OCT1;
                OCT1: phase_r <= lookup.valid ? OCT0 : IDLE;
            endcase
        end
    end

    // Per-lookup context held through both data cycles
    always_ff @(posedge clk) begin
        if (lookup.valid && phase_r != OCT0) begin
            cmd_r <= lookup.cmd;
            fh_r <= force_hit_mode;
            rdp_r <= lookup.is_read_or_probe;
        end
        if (phase_r == OCT0) begin
            oct0_valid_r <= oct_rd.valid;
            oct0_perr_r <= oct_rd.lw_perr;
            oct0_par_r <= oct_rd.lw_parity;
            tag_perr_r <= fh_r ? 3'h0 : tag_rd.tag_perr;
        end
    end

    // ------------------------------------------------------------
    // Error detection at end of lookup (second octaword)
    // ------------------------------------------------------------
    always_comb begin
        dp_all = {oct_rd.lw_perr & {4{oct_rd.valid}},
                  oct0_perr_r & {4{oct0_valid_r}}};
        par_all = {oct_rd.lw_parity, oct0_par_r};
        err_now = (phase_r == OCT1) && !fh_r &&
                  ((|tag_perr_r) || (|dp_all));
        locked = (|tperr_r) || (|dperr_r);
        fh_word = pack_tag(tag_rd);
    end

    // ------------------------------------------------------------
    // Status register: no reset on purpose
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (err_now) begin
            if (!locked || rd_status) begin
                tperr_r <= tag_perr_r;
                dperr_r <= dp_all;
                stat_cmd_r <= cmd_r;
                scnd_r <= 1'b0;
            end else begin
                scnd_r <= 1'b1;
            end
        end else if ((phase_r == OCT1) && fh_r) begin
            // Force-hit ignores the lock, so every lookup reloads the parity bits
            dperr_r <= par_all;
        end else if (rd_status) begin
            tperr_r <= 3'h0;
            dperr_r <= 8'h00;
            stat_cmd_r <= 5'h00;
            scnd_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Address register: no reset on purpose
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (force_hit_mode) begin
            if (phase_r == OCT0 && rdp_r) begin
                cap_r <= fh_word;
            end
        end else if (lookup.valid && phase_r != OCT0 && (!locked || rd_status)) begin
            cap_r <= lookup.addr[ADDR_W-2:CAP_LSB];
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 64'h0000_0000_0000_0000;
        end else if (rd_status) begin
            reg_rdata <= STATUS_RESERVED_VAL | {47'h0, scnd_r, stat_cmd_r, dperr_r, tperr_r};
        end else if (rd_address) begin
            reg_rdata <= {ADDR_HIGH_FILL, 1'b0, cap_r, ADDR_LOW_FILL};
        end else begin
            reg_rdata <= 64'h0000_0000_0000_0000;
        end
    end

    always_comb begin
        error_locked = locked;
    end

endmodule : l2_cache_error_capture
`default_nettype wire

/* tb/l2_cache_error_capture_properties.sv */
// Port-level assertions for the cache error capture block
`timescale 1ns/1ns
`default_nettype none
module l2_err_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic force_hit_mode,
    input wire l2_err_pkg::lookup_req_t lookup,
    input wire l2_err_pkg::tag_read_t tag_rd,
    input wire l2_err_pkg::data_read_t oct_rd,
    input wire logic [l2_err_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [63:0] reg_rdata,
    input wire logic error_locked
);
    import l2_err_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire logic rd_s = reg_rd && reg_addr == L2_ERROR_STATUS_ADDR;
    sequence s_err_first;
        lookup.valid && !force_hit_mode ##1 !force_hit_mode
        && (|tag_rd.tag_perr || (oct_rd.valid && |oct_rd.lw_perr)) ##1 !force_hit_mode;
    endsequence
    sequence s_err_second;
        lookup.valid && !force_hit_mode ##1 !force_hit_mode
        ##1 !force_hit_mode && oct_rd.valid && |oct_rd.lw_perr;
    endsequence
    sequence s_read_twice;
        rd_s && !lookup.valid && !$past(lookup.valid) && !$past(lookup.valid, 2)
        ##1 !lookup.valid ##1 rd_s && !lookup.valid;
    endsequence
    chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside a read");
    chk_status_upper: assert property ($past(rd_s) |-> reg_rdata[63:17] == '0)
        else $error("status upper bits not zero");
    chk_addr_fill: assert property ($past(reg_rd) && $past(reg_addr) == L2_ERROR_ADDRESS_ADDR
        |-> reg_rdata[3:0] == ADDR_LOW_FILL && reg_rdata[63:39] == {ADDR_HIGH_FILL, 1'b0})
        else $error("address register fill bits wrong");
    chk_lock_early: assert property (s_err_first |=> error_locked)
        else $error("no lock after first octaword error");
    chk_lock_late: assert property (s_err_second |=> error_locked)
        else $error("no lock after second octaword error");
    chk_read_unlock: assert property (rd_s && !$past(lookup.valid, 2) |=> !error_locked)
        else $error("status read did not unlock");
    chk_lock_holds: assert property (error_locked && !rd_s && !force_hit_mode |=> error_locked)
        else $error("lock dropped without a status read");
    chk_clear_twice: assert property (s_read_twice |=> reg_rdata == '0)
        else $error("status not cleared by read");
endmodule : l2_err_checker
bind l2_cache_error_capture l2_err_checker u_chk (.clk, .resetn, .force_hit_mode, .lookup,
    .tag_rd, .oct_rd, .reg_addr, .reg_rd, .reg_rdata, .error_locked);
`default_nettype wire

/* tb/l2_cache_error_capture_bench.sv */
// Self-checking bench for the cache error capture block
`timescale 1ns/1ns
`default_nettype none
module l2_cache_error_capture_bench;
    import l2_err_pkg::*;
    localparam logic [39:0] S = L2_ERROR_STATUS_ADDR;
    localparam logic [39:0] AD = L2_ERROR_ADDRESS_ADDR;
    logic clk = 0, resetn = 0, force_hit_mode = 0, reg_wr = 0, reg_rd = 0, error_locked;
    lookup_req_t lookup = '0;
    tag_read_t tag_rd = '0;
    data_read_t oct_rd = '0;
    logic [39:0] reg_addr = '0;
    logic [63:0] reg_wdata = '0, reg_rdata, d, ex;
    logic [34:0] tw = '0;
    logic [4:0] codes [7] = '{5'h06, 5'h05, 5'h04, 5'h03, 5'h01, 5'h09, 5'h11};
    int error_cnt = 0, compares = 0, cyc = 0;
    l2_cache_error_capture dut (.clk, .resetn, .force_hit_mode, .lookup, .tag_rd, .oct_rd,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .error_locked);
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic ck(input string n, input logic [63:0] s, e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : ck
    task automatic rd(input logic [39:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic lk(input logic [4:0] c, input logic [39:0] a, input logic [2:0] t,
                      input logic [3:0] e0, e1);
        lookup <= '{1'b1, c, a, c != 5'h03};
        @(posedge clk);
        lookup <= '0;
        tag_rd <= {t, tw};
        oct_rd <= '{1'b1, e0, e0};
        @(posedge clk);
        tag_rd <= '0;
        oct_rd <= '{1'b1, e1, e1};
        @(posedge clk);
        oct_rd <= '0;
        @(posedge clk);
    endtask : lk
    task automatic rst();
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
    endtask : rst
    function automatic logic [63:0] st(logic s, logic [4:0] c, logic [7:0] p, logic [2:0] t);
        return {47'h0, s, c, p, t};
    endfunction : st
    function automatic logic [63:0] ea(logic [39:0] a);
        return {ADDR_HIGH_FILL, 1'b0, a[38:4], ADDR_LOW_FILL};
    endfunction : ea
    task automatic give_verdict();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst();
        rd(S);
        rd(S);
        ck("status cleared", d, '0);
        rd(40'h0);
        ck("unmapped read", d, '0);
        lk(5'h06, 40'h12_3456_7890, 3'h2, 4'h0, 4'h0);
        lk(5'h0b, 40'h22_2222_2220, 3'h0, 4'h2, 4'h0);
        reg_wr <= 1'b1;
        reg_addr <= S;
        reg_wdata <= '1;
        @(posedge clk);
        reg_wr <= 1'b0;
        rst();
        rd(AD);
        ck("locked address", d, ea(40'h12_3456_7890));
        rd(S);
        ck("locked status", d, st(1'b1, 5'h06, 8'h00, 3'h2));
        foreach (codes[i]) begin
            lk(codes[i], 40'hf1_2345_6780, 3'h0, 4'h1, 4'h8);
            rd(S);
            ck("one transaction", d, st(1'b0, codes[i], 8'h81, 3'h0));
        end
        lk(5'h01, 40'h8f_edcb_a990, 3'h0, 4'h0, 4'h0);
        rd(AD);
        ck("open address", d, ea(40'h8f_edcb_a990));
        force_hit_mode <= 1'b1;
        tw = {1'b1, 3'h5, 3'h3, 2'h2, 2'h1, 24'hab_cdef};
        lk(5'h01, 40'h0, 3'h7, 4'h5, 4'ha);
        tw = {1'b0, 3'h2, 3'h4, 2'h1, 2'h2, 24'h12_3456};
        lk(5'h09, 40'h0, 3'h7, 4'h3, 4'hc);
        ex = {ADDR_HIGH_FILL, 1'b0, tw[23:0], tw[25:24], tw[27:26], tw[30:28], tw[33:31],
              tw[34], ADDR_LOW_FILL};
        repeat (5) @(posedge clk);
        rd(S);
        ck("force hit status", {d[16], d[10:0]}, {1'b0, 8'hc3, 3'h0});
        tw = '1;
        lk(5'h03, 40'h0, 3'h0, 4'h0, 4'h0);
        repeat (5) @(posedge clk);
        rd(AD);
        ck("force hit tag", d, ex);
        force_hit_mode <= 1'b0;
        give_verdict();
    end
endmodule : l2_cache_error_capture_bench
`default_nettype wire
